// ---- design/dbg_regs_pkg.sv ----
// shared constants, types and states for the debug scratch and command registers
package dbg_regs_pkg;
	localparam logic [7:0] SCRATCH_A_OFFSET = 8'h18;
	localparam logic [7:0] SCRATCH_B_OFFSET = 8'h19;
	localparam logic [7:0] CMD_STATUS_OFFSET = 8'h1A;
	localparam logic [15:0] SCRATCH_RESET = 16'h0000;
	localparam logic [7:0] CMD_STATUS_RESET = 8'h00;
	localparam int CMD_LSB = 0;
	localparam int CMD_WIDTH = 4;
	localparam int SCAN_WIDTH = 8;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_READ_REG = 4'h1,
		CMD_READ_DATA = 4'h2,
		CMD_READ_STACK = 4'h3,
		CMD_WRITE_REG = 4'h4,
		CMD_WRITE_DATA = 4'h5,
		CMD_TRACE = 4'h6,
		CMD_RETURN = 4'h7
	} host_cmd_t;

	typedef enum {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
		TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} tap_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} cpu_req_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jtag_in_t;
endpackage

// ---- design/debug_scratch_and_command_regs.sv ----
// debug scratch registers, debug command register and the jtag scan path that feeds it
//
// How it works
// - Both scratch registers clear to 0000h on power-on reset or in tap test-logic-reset.
// - The cpu reads and writes both scratch registers freely in background and debug mode.
// - Each scratch register holds a full 16-bit value for rom routines to park registers.
// - The command register clears to 00h on power-on reset or in tap test-logic-reset.
// - The command register reads freely and only the debug engine changes it.
// - The host reaches the command register with a jtag data scan that the device services.
// - In debug mode the engine loads the pending host command, or 00h for codes 8 to F, into the command field.
// - The command field is bits 3..0 with codes 0 to 7 from no-op to return-to-background.
`timescale 1ns/10ps
module debug_scratch_and_command_regs #(
	parameter int DATA_WIDTH = 16,
	parameter int STATUS_WIDTH = 8
) (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire dbg_regs_pkg::cpu_req_t CPU_REQ,
	output logic [DATA_WIDTH-1:0] CPU_RDATA,
	input wire logic DEBUG_MODE,
	input wire dbg_regs_pkg::jtag_in_t JTAG_IN,
	output logic TDO_OUT,
	output logic TDO_OE_N,
	output logic [STATUS_WIDTH-1:0] CMD_STATUS,
	output logic TAP_IN_RESET
);
	logic [2:0] jtag_sync;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic tck_prev_reg;
	logic tck_rise;
	logic tck_fall;
	dbg_regs_pkg::tap_state_t tap_reg;
	dbg_regs_pkg::tap_state_t tap_next;
	logic tlr_clear;
	logic [DATA_WIDTH-1:0] scratch_a_reg;
	logic [DATA_WIDTH-1:0] scratch_b_reg;
	logic [STATUS_WIDTH-1:0] cmd_status_reg;
	logic [STATUS_WIDTH-1:0] cmd_status_next;
	logic [dbg_regs_pkg::SCAN_WIDTH-1:0] scan_reg;
	logic [dbg_regs_pkg::CMD_WIDTH-1:0] host_cmd;

	pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.async_in({JTAG_IN.tck, JTAG_IN.tms, JTAG_IN.tdi}),
		.sync_out(jtag_sync)
	);

	assign tck_s = jtag_sync[2];
	assign tms_s = jtag_sync[1];
	assign tdi_s = jtag_sync[0];
	assign tck_rise = tck_s && !tck_prev_reg;
	assign tck_fall = !tck_s && tck_prev_reg;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			tck_prev_reg <= 1'b0;
		end else begin
			tck_prev_reg <= tck_s;
		end
	end

	// standard tap walk, stepped on each sampled rising tck edge
	always_comb begin
		tap_next = tap_reg;
		case (tap_reg)
			dbg_regs_pkg::TAP_RESET:
				tap_next = tms_s ? dbg_regs_pkg::TAP_RESET : dbg_regs_pkg::TAP_IDLE;
			dbg_regs_pkg::TAP_IDLE:
				tap_next = tms_s ? dbg_regs_pkg::TAP_SEL_DR : dbg_regs_pkg::TAP_IDLE;
			dbg_regs_pkg::TAP_SEL_DR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_SEL_IR : dbg_regs_pkg::TAP_CAP_DR;
			dbg_regs_pkg::TAP_CAP_DR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_EXIT1_DR : dbg_regs_pkg::TAP_SHIFT_DR;
			dbg_regs_pkg::TAP_SHIFT_DR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_EXIT1_DR : dbg_regs_pkg::TAP_SHIFT_DR;
			dbg_regs_pkg::TAP_EXIT1_DR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_UPD_DR : dbg_regs_pkg::TAP_PAUSE_DR;
			dbg_regs_pkg::TAP_PAUSE_DR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_EXIT2_DR : dbg_regs_pkg::TAP_PAUSE_DR;
			dbg_regs_pkg::TAP_EXIT2_DR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_UPD_DR : dbg_regs_pkg::TAP_SHIFT_DR;
			dbg_regs_pkg::TAP_UPD_DR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_SEL_DR : dbg_regs_pkg::TAP_IDLE;
			dbg_regs_pkg::TAP_SEL_IR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_RESET : dbg_regs_pkg::TAP_CAP_IR;
			dbg_regs_pkg::TAP_CAP_IR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_EXIT1_IR : dbg_regs_pkg::TAP_SHIFT_IR;
			dbg_regs_pkg::TAP_SHIFT_IR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_EXIT1_IR : dbg_regs_pkg::TAP_SHIFT_IR;
			dbg_regs_pkg::TAP_EXIT1_IR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_UPD_IR : dbg_regs_pkg::TAP_PAUSE_IR;
			dbg_regs_pkg::TAP_PAUSE_IR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_EXIT2_IR : dbg_regs_pkg::TAP_PAUSE_IR;
			dbg_regs_pkg::TAP_EXIT2_IR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_UPD_IR : dbg_regs_pkg::TAP_SHIFT_IR;
			dbg_regs_pkg::TAP_UPD_IR:
				tap_next = tms_s ? dbg_regs_pkg::TAP_SEL_DR : dbg_regs_pkg::TAP_IDLE;
			default: tap_next = dbg_regs_pkg::TAP_RESET;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			tap_reg <= dbg_regs_pkg::TAP_RESET;
		end else if (tck_rise) begin
			tap_reg <= tap_next;
		end
	end

	// clearing follows the tap state itself, so it holds for as long as the tap sits there
	assign tlr_clear = (tap_reg == dbg_regs_pkg::TAP_RESET);

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			TAP_IN_RESET <= 1'b1;
		end else begin
			TAP_IN_RESET <= tlr_clear;
		end
	end

	// scratch registers: reset clear outranks a cpu write in the same cycle
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			scratch_a_reg <= dbg_regs_pkg::SCRATCH_RESET;
			scratch_b_reg <= dbg_regs_pkg::SCRATCH_RESET;
		end else if (tlr_clear) begin
			scratch_a_reg <= dbg_regs_pkg::SCRATCH_RESET;
			scratch_b_reg <= dbg_regs_pkg::SCRATCH_RESET;
		end else if (CPU_REQ.wr) begin
			// no mode gating: background and debug alike
			if (CPU_REQ.addr == dbg_regs_pkg::SCRATCH_A_OFFSET) begin
				scratch_a_reg <= CPU_REQ.wdata;
			end
			if (CPU_REQ.addr == dbg_regs_pkg::SCRATCH_B_OFFSET) begin
				scratch_b_reg <= CPU_REQ.wdata;
			end
		end
	end

	// cpu read port, one cycle latency; unmapped reads give zero
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			CPU_RDATA <= '0;
		end else if (CPU_REQ.rd) begin
			case (CPU_REQ.addr)
				dbg_regs_pkg::SCRATCH_A_OFFSET: CPU_RDATA <= scratch_a_reg;
				dbg_regs_pkg::SCRATCH_B_OFFSET: CPU_RDATA <= scratch_b_reg;
				dbg_regs_pkg::CMD_STATUS_OFFSET: begin
					CPU_RDATA <= {{(DATA_WIDTH-STATUS_WIDTH){1'b0}}, cmd_status_reg};
				end
				default: CPU_RDATA <= '0;
			endcase
		end
	end

	// scan register: capture shows the command register, shift takes tdi lsb first
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			scan_reg <= '0;
		end else if (tck_rise) begin
			if (tap_reg == dbg_regs_pkg::TAP_CAP_DR) begin
				scan_reg <= cmd_status_reg;
			end else if (tap_reg == dbg_regs_pkg::TAP_SHIFT_DR) begin
				scan_reg <= {tdi_s, scan_reg[dbg_regs_pkg::SCAN_WIDTH-1:1]};
			end
		end
	end

	// tdo changes on the falling edge so the host samples a settled bit
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			TDO_OUT <= 1'b0;
			TDO_OE_N <= 1'b1;
		end else if (tck_fall) begin
			TDO_OUT <= scan_reg[0];
			TDO_OE_N <= (tap_reg != dbg_regs_pkg::TAP_SHIFT_DR);
		end
	end

	assign host_cmd = scan_reg[dbg_regs_pkg::CMD_LSB +: dbg_regs_pkg::CMD_WIDTH];

	// only codes 0..7 are known; upper bits never set
	always_comb begin
		cmd_status_next = '0;
		case (host_cmd)
			dbg_regs_pkg::CMD_NOP,
			dbg_regs_pkg::CMD_READ_REG,
			dbg_regs_pkg::CMD_READ_DATA,
			dbg_regs_pkg::CMD_READ_STACK,
			dbg_regs_pkg::CMD_WRITE_REG,
			dbg_regs_pkg::CMD_WRITE_DATA,
			dbg_regs_pkg::CMD_TRACE,
			dbg_regs_pkg::CMD_RETURN: begin
				cmd_status_next[dbg_regs_pkg::CMD_LSB +: dbg_regs_pkg::CMD_WIDTH] = host_cmd;
			end
			default: cmd_status_next = '0;
		endcase
	end

	// command register: engine only, cpu write path deliberately absent
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			cmd_status_reg <= dbg_regs_pkg::CMD_STATUS_RESET;
		end else if (tlr_clear) begin
			cmd_status_reg <= dbg_regs_pkg::CMD_STATUS_RESET;
		end else if (tck_rise && tap_reg == dbg_regs_pkg::TAP_UPD_DR && DEBUG_MODE) begin
			cmd_status_reg <= cmd_status_next;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			CMD_STATUS <= dbg_regs_pkg::CMD_STATUS_RESET;
		end else begin
			CMD_STATUS <= cmd_status_reg;
		end
	end
endmodule

// ---- design/pin_sync.sv ----
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ---- test/debug_scratch_and_command_regs_sva.sv ----
// port assertions for the debug scratch and command registers
`timescale 1ns/10ps
module debug_scratch_and_command_regs_sva #(
	parameter int DATA_WIDTH = 16,
	parameter int STATUS_WIDTH = 8
) (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire dbg_regs_pkg::cpu_req_t CPU_REQ,
	input wire logic [DATA_WIDTH-1:0] CPU_RDATA,
	input wire logic DEBUG_MODE,
	input wire dbg_regs_pkg::jtag_in_t JTAG_IN,
	input wire logic TDO_OUT,
	input wire logic TDO_OE_N,
	input wire logic [STATUS_WIDTH-1:0] CMD_STATUS,
	input wire logic TAP_IN_RESET
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	wire scr = CPU_REQ.addr[7:1] == 7'h0C;
	property p_tlr_cmd; TAP_IN_RESET [*2] |=> CMD_STATUS == 8'h00; endproperty
	a_tlr_cmd: assert property (p_tlr_cmd) else $error("cmd kept in tap reset");
	property p_top_zero; CMD_STATUS[7:3] == 5'h00; endproperty
	a_top_zero: assert property (p_top_zero) else $error("cmd bits 7..3 set");
	property p_tlr_scr; TAP_IN_RESET && $past(TAP_IN_RESET) && CPU_REQ.rd && scr
		|=> CPU_RDATA == 16'h0000; endproperty
	a_tlr_scr: assert property (p_tlr_scr) else $error("scratch kept in tap reset");
	property p_cmd_rd; CPU_REQ.rd && CPU_REQ.addr == 8'h1A |=> CPU_RDATA == {8'h00, CMD_STATUS};
	endproperty
	a_cmd_rd: assert property (p_cmd_rd) else $error("cmd read wrong");
	property p_hold; !CPU_REQ.rd |=> $stable(CPU_RDATA); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	// only a load in debug mode or a tap reset may move the command
	property p_cmd_src; $changed(CMD_STATUS) |-> $past(DEBUG_MODE) || $past(DEBUG_MODE, 2)
		|| $past(TAP_IN_RESET) || $past(TAP_IN_RESET, 2); endproperty
	a_cmd_src: assert property (p_cmd_src) else $error("cmd changed outside debug");
	property p_oe; !TDO_OE_N |-> !TAP_IN_RESET; endproperty
	a_oe: assert property (p_oe) else $error("tdo driven in tap reset");
	property p_wr_rd; CPU_REQ.rd && scr && $past(CPU_REQ.wr) && $past(CPU_REQ.addr) == CPU_REQ.addr
		&& !TAP_IN_RESET && !$past(TAP_IN_RESET) |=> CPU_RDATA == $past(CPU_REQ.wdata, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("scratch write lost");
endmodule

// ---- test/jtag_host_model.sv ----
// jtag host: tck idles low between frames, 125 ns period
`timescale 1ns/10ps
module jtag_host_model (
	output dbg_regs_pkg::jtag_in_t jtag,
	input wire logic tdo,
	input wire logic tdo_oe_n
);
	initial jtag = '0;
	// tdo read as z when undriven so a missing enable shows up
	task automatic tick(input logic ms, input logic di, output logic o);
		jtag.tms = ms;
		jtag.tdi = di;
		#62.5;
		o = tdo_oe_n ? 1'bz : tdo;
		jtag.tck = 1'b1;
		#62.5;
		jtag.tck = 1'b0;
	endtask
	task automatic scan(input logic [7:0] d, output logic [7:0] q);
		logic o;
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < 8; i++) begin
			tick(i == 7, d[i], q[i]);
		end
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask
	task automatic to_reset();
		logic o;
		repeat (5) tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask
endmodule

// ---- test/test_debug_scratch_and_command_regs.sv ----
// self-checking bench for the debug scratch and command registers
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_debug_scratch_and_command_regs;
	logic CLK_SYS = 1'b0;
	logic RESET_N = 1'b0;
	logic DEBUG_MODE = 1'b0;
	dbg_regs_pkg::cpu_req_t req = '0;
	dbg_regs_pkg::jtag_in_t jtag;
	logic tdo, tdo_oe_n, tap_rst;
	logic [7:0] cmd_st, cmd_exp, q, d;
	logic [15:0] scr [2];
	logic [15:0] v, r, rdata;
	int failures = 0;
	int checked = 0;
	debug_scratch_and_command_regs debug_scratch_and_command_regs_inst (.CLK_SYS(CLK_SYS),
		.RESET_N(RESET_N), .CPU_REQ(req), .CPU_RDATA(rdata), .DEBUG_MODE(DEBUG_MODE),
		.JTAG_IN(jtag), .TDO_OUT(tdo), .TDO_OE_N(tdo_oe_n), .CMD_STATUS(cmd_st),
		.TAP_IN_RESET(tap_rst));
	jtag_host_model jtag_host_model_inst (.jtag(jtag), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
	function automatic logic [15:0] rd_exp(input logic [7:0] a);
		return a == 8'h18 ? scr[0] : a == 8'h19 ? scr[1] :
			a == 8'h1A ? {8'h00, cmd_exp} : 16'h0000;
	endfunction
	function automatic logic [7:0] cmd_of(input logic [7:0] x);
		return x[3] ? 8'h00 : {4'h0, x[3:0]};
	endfunction
	// request held until the next call so requests run back to back
	task automatic cpu(input logic w, input logic [7:0] a, input logic [15:0] wd,
		output logic [15:0] o);
		req = '{w, !w, a, wd};
		@(posedge CLK_SYS);
		#1;
		o = rdata;
	endtask
	task automatic check_regs();
		for (int i = 0; i < 3; i++) begin
			cpu(1'b0, 8'h18 + 8'(i), 16'h0000, r);
			`CHK("reg read", rd_exp(8'h18 + 8'(i)), r)
		end
	endtask
	task complete_run();
		if (failures == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		forever #5 CLK_SYS = ~CLK_SYS;
	end
	initial begin
		#1ms;
		failures++;
		complete_run();
	end
	initial begin
		v = 16'($urandom(20708));
		scr[0] = 16'h0000;
		scr[1] = 16'h0000;
		cmd_exp = 8'h00;
		repeat (3) @(posedge CLK_SYS);
		#1;
		RESET_N = 1'b1;
		cpu(1'b1, 8'h18, 16'hFFFF, r);
		check_regs();
		`CHK("tap reset", 1'b1, tap_rst)
		req = '0;
		jtag_host_model_inst.to_reset();
		@(posedge CLK_SYS);
		#1;
		`CHK("tap reset", 1'b0, tap_rst)
		for (int n = 0; n < 40; n++) begin
			d = 8'h18 + 8'($urandom % 4);
			v = 16'($urandom);
			DEBUG_MODE = 1'($urandom);
			if ($urandom % 2) begin
				cpu(1'b1, d, v, r);
				if (d[7:1] == 7'h0C) scr[d[0]] = v;
			end else begin
				cpu(1'b0, d, 16'h0000, r);
				`CHK("cpu read", rd_exp(d), r)
			end
		end
		req = '0;
		DEBUG_MODE = 1'b1;
		// codes 4..F, 0..3, then 4 with debug mode off
		for (int c = 0; c < 17; c++) begin
			d = {4'($urandom), 4'(c + 4)};
			if (c == 16) DEBUG_MODE = 1'b0;
			jtag_host_model_inst.scan(d, q);
			`CHK("capture", cmd_exp, q)
			if (DEBUG_MODE) cmd_exp = cmd_of(d);
			`CHK("command", cmd_exp, cmd_st)
			@(posedge CLK_SYS);
			#1;
			cpu(1'b1, 8'h1A, 16'hFFFF, r);
			check_regs();
			req = '0;
		end
		// let an edge pass so req is not assigned twice in one step
		@(posedge CLK_SYS);
		#1;
		cpu(1'b1, 8'h18, 16'hA5A5, r);
		cpu(1'b1, 8'h19, 16'h5A5A, r);
		cpu(1'b0, 8'h19, 16'h0000, r);
		`CHK("scratch b", 16'h5A5A, r)
		req = '0;
		jtag_host_model_inst.to_reset();
		scr[0] = 16'h0000;
		scr[1] = 16'h0000;
		cmd_exp = 8'h00;
		@(posedge CLK_SYS);
		#1;
		check_regs();
		`CHK("command", 8'h00, cmd_st)
		req = '0;
		complete_run();
	end
endmodule
bind debug_scratch_and_command_regs debug_scratch_and_command_regs_sva #(
	.DATA_WIDTH(DATA_WIDTH), .STATUS_WIDTH(STATUS_WIDTH)) chk_inst (.CLK_SYS(CLK_SYS),
	.RESET_N(RESET_N), .CPU_REQ(CPU_REQ), .CPU_RDATA(CPU_RDATA), .DEBUG_MODE(DEBUG_MODE),
	.JTAG_IN(JTAG_IN), .TDO_OUT(TDO_OUT), .TDO_OE_N(TDO_OE_N), .CMD_STATUS(CMD_STATUS),
	.TAP_IN_RESET(TAP_IN_RESET));
